/* src/bst_defines.vh */
// Constants for the bus-slave test sequencer: offsets, modes, fields, resets
`ifndef BST_DEFINES_VH
`define BST_DEFINES_VH

// Test modes written to the state location
`define BST_MODE_EXIT 3'h0
`define BST_MODE_FUNC 3'h1
`define BST_MODE_TAG 3'h2
`define BST_MODE_IMMU 3'h3
`define BST_MODE_DMMU 3'h4
`define BST_MODE_ICACHE 3'h5
`define BST_MODE_DCACHE 3'h6

// Byte offsets of the state and tag RAM test locations
`define BST_OFS_STATE 6'h00
`define BST_OFS_TAG_INDEX 6'h04
`define BST_OFS_TAG_SEGMENT 6'h08
`define BST_OFS_TAG_PATTERN 6'h0c
`define BST_OFS_TAG_WR_INVERT 6'h10
`define BST_OFS_TAG_WR_INCR 6'h14
`define BST_OFS_TAG_READ 6'h18

// Burst-length field: address bits 8:6, offsets 0x000 to 0x1c0
`define BST_BURST_LSB 6
`define BST_BURST_MSB 8

// Functional location select bits sit in address 10:2 (location = address bit minus 2)
`define BST_FSEL_LSB 2
`define BST_FSEL_MSB 10
`define BST_LOC_COPROC_DIN 4'd8
`define BST_LOC_INPUTS 4'd7
`define BST_LOC_READ_DIN 4'd6
`define BST_LOC_WDATA_OUT 4'd5
`define BST_LOC_COPROC_DOUT 4'd4
`define BST_LOC_COPROC_INSTR 4'd3
`define BST_LOC_STATUS_ONE 4'd2
`define BST_LOC_STATUS_TWO 4'd1
`define BST_LOC_ADDR_OUT 4'd0
`define BST_LOC_LAST_WRITE 4'd6

// Tag RAM read word places the line at 31:6
`define BST_TAG_RD_LSB 6

// Reset values
`define BST_RST_MODE 3'h0
`define BST_RST_WORD 32'h0000_0000
`define BST_RST_INDEX 6'h00
`define BST_RST_SEGMENT 7'h00
`define BST_RST_PATTERN 26'h000_0000

`endif

/* src/bst_tag_ram.v */
// Tag RAM array under test: synchronous write, registered read
`timescale 1ns/1ps
module bst_tag_ram
#(
    parameter AW = 8,
    parameter DW = 26
)
(
    input wire core_clk,          // Core clock
    input wire wr_en,             // Write strobe
    input wire [AW-1:0] wr_addr,  // Write line address
    input wire [DW-1:0] wr_data,  // Write line data
    input wire [AW-1:0] rd_addr,  // Read line address, sampled every edge
    output reg [DW-1:0] rd_data_q // Registered read data
);

reg [DW-1:0] mem [0:(1<<AW)-1];

always @(posedge core_clk)
begin
    if (wr_en)
    begin
        mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
end

endmodule

/* src/bst_sequencer.v */
// Bus-slave test sequencer: functional, burst and tag RAM test locations
`timescale 1ns/1ps
`include "bst_defines.vh"
module bst_sequencer
#(
    parameter SEG_BITS = 2,   // Implemented segments = 2**SEG_BITS
    parameter LINE_W = 26
)
(
    input wire core_clk,                      // 200 MHz clock
    input wire arst_n,                        // Asynchronous reset, active low
    input wire asb_sel,                       // Slave selected
    input wire asb_trans,                     // Transfer taken this cycle
    input wire asb_write,                     // 1 write, 0 read
    input wire [11:0] asb_addr,               // Test address in, byte address
    input wire [31:0] asb_wdata,              // Write data
    output reg [31:0] asb_rdata_q,            // Read data, valid with asb_rvalid_q
    output reg asb_rvalid_q,                  // Read data valid pulse
    output reg [2:0] test_mode_q,             // Current test mode
    output reg core_isolate_q,                // Core cut from its pins, drivers off
    output reg core_step_q,                   // One functional core clock pulse
    output reg [31:0] core_input_vector_q,    // Tester-written core inputs
    output reg [31:0] coproc_data_to_core_q,  // Tester-written coprocessor data in
    output reg [31:0] core_read_data_in_q,    // Tester-written read data in
    input wire [31:0] core_write_data_out,    // Core write data out
    input wire [31:0] coproc_data_out,        // Coprocessor data out
    input wire [31:0] coproc_instr_out,       // Coprocessor instruction out
    input wire [21:0] core_status_word_one,   // Status one, packed by the core
    input wire [31:0] address_out,            // Core address out
    input wire boundary_drive_enable,         // Boundary drive enable echo
    input wire debug_acknowledge,             // Debug acknowledge
    input wire ext_clock_echo,                // External clock echo
    input wire [3:0] instr_reg_echo,          // Instruction register echo
    input wire [1:0] range_out,               // Watchpoint range outputs 0 and 1
    input wire [4:0] scan_chain_select_echo,  // Scan chain select echo
    input wire [3:0] tap_state_echo,          // Tap state echo
    input wire tdo_out,                       // Test data out
    input wire tdo_enable_n,                  // Test data out enable, active low
    input wire [8:0] scan_clock_echo,         // Scan and capture clock echoes, 11:3
    input wire comms_receive_flag,            // Comms receive flag
    input wire comms_transmit_flag,           // Comms transmit flag
    input wire internal_debug_request         // Internal debug request
);

// ----------------------------------------------------------------
// Helper functions
// ----------------------------------------------------------------
// Highest set bit of mask at or below 'top'; 4'hf if none
function [3:0] pick_below;
    input [8:0] mask;
    input [3:0] top;
    integer i;
    begin
        pick_below = 4'hf;
        for (i = 0; i < 9; i = i + 1)
        begin
            if (mask[i] && (i <= top))
            begin
                pick_below = i[3:0];
            end
        end
    end
endfunction

// The tester reads coprocessor instruction before coprocessor data out,
// so the walk runs over ranks in which those two select bits trade places
function [8:0] rank_mask;
    input [8:0] sel;
    begin
        rank_mask = {sel[8:5], sel[3], sel[4], sel[2:0]};
    end
endfunction

// Location named by a walk rank; the swap is its own inverse
function [3:0] rank_loc;
    input [3:0] r;
    begin
        if (r == `BST_LOC_COPROC_DOUT)
        begin
            rank_loc = `BST_LOC_COPROC_INSTR;
        end
        else if (r == `BST_LOC_COPROC_INSTR)
        begin
            rank_loc = `BST_LOC_COPROC_DOUT;
        end
        else
        begin
            rank_loc = r;
        end
    end
endfunction

// Packs the gapped pattern write word into a 26-bit line
function [25:0] unpack_pattern;
    input [31:0] w;
    begin
        unpack_pattern = {w[28:24], w[22:16], w[14:8], w[6:0]};
    end
endfunction

// ----------------------------------------------------------------
// Access decode
// ----------------------------------------------------------------
wire acc = asb_sel & asb_trans;
wire [5:0] loc_ofs = asb_addr[5:0];
wire [2:0] burst_code = asb_addr[`BST_BURST_MSB:`BST_BURST_LSB];
wire [8:0] fsel = asb_addr[`BST_FSEL_MSB:`BST_FSEL_LSB];
wire is_state = (asb_addr == 12'h000);
wire in_func = (test_mode_q == `BST_MODE_FUNC);
wire in_tag = (test_mode_q == `BST_MODE_TAG);
// Burst offsets 0x000..0x1c0 alias for the invert, increment and read locations; index, segment and pattern load at 0x000 only; bits 11:9 must be clear
wire burst_ok = (asb_addr[11:9] == 3'h0) && (burst_code <= 3'h7);

reg [8:0] fmask_q;
reg [3:0] fptr_q;
reg [5:0] tag_index_q;
reg [6:0] tag_segment_q;
reg [25:0] tag_pattern_q;

// ----------------------------------------------------------------
// Functional location sequencing
// ----------------------------------------------------------------
// A new select value restarts the walk at its highest rank
// The walk runs in rank order; fptr_q holds a rank, fcur the location it names
wire [8:0] frank = rank_mask(fsel);
wire fnew = (fsel != fmask_q);
wire [3:0] frank_cur = fnew ? pick_below(frank, 4'd8) : fptr_q;
wire [3:0] fbelow = (frank_cur == 4'd0) ? 4'hf : pick_below(frank, frank_cur - 4'd1);
wire [3:0] fnext = (fbelow == 4'hf) ? pick_below(frank, 4'd8) : fbelow;
wire [3:0] fcur = rank_loc(frank_cur);
wire func_acc = acc & in_func & ~is_state & (frank_cur != 4'hf);
// The core steps once the last selected write location has been written;
// write locations keep their ranks, so the test works on ranks
wire last_write = (frank_cur >= `BST_LOC_LAST_WRITE) &&
                  ((fnext < `BST_LOC_LAST_WRITE) || (fnext >= frank_cur));

// ----------------------------------------------------------------
// Tag RAM
// ----------------------------------------------------------------
wire tag_acc = acc & in_tag & ~is_state & burst_ok;
wire tag_wr_inv = tag_acc & asb_write & (loc_ofs == `BST_OFS_TAG_WR_INVERT);
wire tag_wr_inc = tag_acc & asb_write & (loc_ofs == `BST_OFS_TAG_WR_INCR);
wire tag_rd = tag_acc & ~asb_write & (loc_ofs == `BST_OFS_TAG_READ);
wire tag_ld_index = tag_acc & asb_write & (loc_ofs == `BST_OFS_TAG_INDEX) & (burst_code == 3'h0);
wire tag_ld_seg = tag_acc & asb_write & (loc_ofs == `BST_OFS_TAG_SEGMENT) & (burst_code == 3'h0);
wire tag_ld_pat = tag_acc & asb_write & (loc_ofs == `BST_OFS_TAG_PATTERN) & (burst_code == 3'h0);
// Only the low segments exist; writes elsewhere are dropped, reads give zero
wire seg_impl = (tag_segment_q[6:SEG_BITS] == {(7-SEG_BITS){1'b0}});

reg [5:0] tag_index_d;
reg [6:0] tag_segment_d;
wire [25:0] tag_line_q;

always @*
begin
    tag_index_d = tag_index_q;
    tag_segment_d = tag_segment_q;
    if (tag_ld_index)
    begin
        tag_index_d = asb_wdata[5:0];
    end
    else if (tag_wr_inv | tag_wr_inc | tag_rd)
    begin
        tag_index_d = tag_index_q + 6'h01;
    end
    if (tag_ld_seg)
    begin
        tag_segment_d = asb_wdata[6:0];
    end
end

// Read address follows the next index so each beat of a read burst sees its line
bst_tag_ram #(.AW(SEG_BITS + 6), .DW(LINE_W)) u_tag_ram
(
    .core_clk(core_clk),
    .wr_en((tag_wr_inv | tag_wr_inc) & seg_impl),
    .wr_addr({tag_segment_q[SEG_BITS-1:0], tag_index_q}),
    .wr_data(tag_pattern_q),
    .rd_addr({tag_segment_d[SEG_BITS-1:0], tag_index_d}),
    .rd_data_q(tag_line_q)
);

// ----------------------------------------------------------------
// Read data selection
// ----------------------------------------------------------------
reg [31:0] rd_word;

always @*
begin
    rd_word = `BST_RST_WORD;
    if (tag_rd && seg_impl)
    begin
        rd_word = {tag_line_q, {`BST_TAG_RD_LSB{1'b0}}};
    end
    else if (func_acc)
    begin
        case (fcur)
            `BST_LOC_WDATA_OUT: rd_word = core_write_data_out;
            `BST_LOC_COPROC_DOUT: rd_word = coproc_data_out;
            `BST_LOC_COPROC_INSTR: rd_word = coproc_instr_out;
            `BST_LOC_STATUS_ONE: rd_word = {10'h000, core_status_word_one};
            `BST_LOC_STATUS_TWO: rd_word = {boundary_drive_enable, debug_acknowledge, ext_clock_echo,
                                            instr_reg_echo, range_out[0], range_out[1],
                                            scan_chain_select_echo, tap_state_echo, tdo_out,
                                            tdo_enable_n, scan_clock_echo, comms_receive_flag,
                                            comms_transmit_flag, internal_debug_request};
            `BST_LOC_ADDR_OUT: rd_word = address_out;
            default: rd_word = `BST_RST_WORD;
        endcase
    end
end

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
always @(posedge core_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        test_mode_q <= `BST_RST_MODE;
        core_isolate_q <= 1'b0;
        core_step_q <= 1'b0;
        core_input_vector_q <= `BST_RST_WORD;
        coproc_data_to_core_q <= `BST_RST_WORD;
        core_read_data_in_q <= `BST_RST_WORD;
        asb_rdata_q <= `BST_RST_WORD;
        asb_rvalid_q <= 1'b0;
        fmask_q <= 9'h000;
        fptr_q <= 4'hf;
        tag_index_q <= `BST_RST_INDEX;
        tag_segment_q <= `BST_RST_SEGMENT;
        tag_pattern_q <= `BST_RST_PATTERN;
    end
    else
    begin
        core_step_q <= 1'b0;
        asb_rvalid_q <= 1'b0;
        tag_index_q <= tag_index_d;
        tag_segment_q <= tag_segment_d;
        // State location: mode codes above the defined set are ignored
        if (acc && asb_write && is_state && (asb_wdata[31:3] == 29'h0) && (asb_wdata[2:0] != 3'h7))
        begin
            test_mode_q <= asb_wdata[2:0];
            core_isolate_q <= (asb_wdata[2:0] == `BST_MODE_FUNC);
            fmask_q <= 9'h000;
            fptr_q <= 4'hf;
        end
        if (func_acc)
        begin
            fmask_q <= fsel;
            fptr_q <= fnext;
            if (asb_write)
            begin
                case (fcur)
                    `BST_LOC_COPROC_DIN: coproc_data_to_core_q <= asb_wdata;
                    `BST_LOC_INPUTS: core_input_vector_q <= asb_wdata;
                    `BST_LOC_READ_DIN: core_read_data_in_q <= asb_wdata;
                    default: core_read_data_in_q <= core_read_data_in_q;
                endcase
                core_step_q <= last_write;
            end
        end
        if (tag_ld_pat)
        begin
            tag_pattern_q <= unpack_pattern(asb_wdata);
        end
        else if (tag_wr_inv)
        begin
            tag_pattern_q <= ~tag_pattern_q;
        end
        else if (tag_wr_inc)
        begin
            tag_pattern_q <= tag_pattern_q + 26'h000_0001;
        end
        if (acc && !asb_write)
        begin
            asb_rdata_q <= rd_word;
            asb_rvalid_q <= 1'b1;
        end
    end
end

endmodule

/* src/bst_unused_placeholder_none.v */
// Intentionally holds no logic; kept empty module-free
`timescale 1ns/1ps

/* dv/bst_sequencer_sva.sv */
// Port-level checker for the bus-slave test sequencer
`timescale 1ns/1ps
module bst_sequencer_sva
(
    input wire core_clk,                   // Clock
    input wire arst_n,                     // Reset, active low
    input wire asb_sel,                    // Slave select
    input wire asb_trans,                  // Transfer
    input wire asb_write,                  // Direction
    input wire [11:0] asb_addr,            // Byte address
    input wire [31:0] asb_wdata,           // Write data
    input wire [31:0] asb_rdata_q,         // Read data
    input wire asb_rvalid_q,               // Read valid
    input wire [2:0] test_mode_q,          // Test mode
    input wire core_isolate_q,             // Core isolated
    input wire core_step_q,                // Core clock pulse
    input wire [31:0] core_input_vector_q  // Core inputs
);
    wire rd_take = asb_sel & asb_trans & ~asb_write;
    wire wr_take = asb_sel & asb_trans & asb_write;
    wire st_wr = wr_take & (asb_addr == 12'h000);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    read_answer_a: assert property (rd_take |=> asb_rvalid_q)
        else $error("read not answered next cycle");
    answer_cause_a: assert property (asb_rvalid_q |-> $past(rd_take))
        else $error("read valid without a read");
    func_enter_a: assert property (st_wr && asb_wdata == 32'h1 |=> test_mode_q == 3'h1 && core_isolate_q)
        else $error("functional mode not entered");
    mode_exit_a: assert property (st_wr && asb_wdata == 32'h0 |=> test_mode_q == 3'h0 && !core_isolate_q)
        else $error("test mode not left");
    mode_hold_a: assert property (!st_wr |=> $stable(test_mode_q))
        else $error("mode changed without a state write");
    step_cause_a: assert property (core_step_q |-> $past(wr_take) && test_mode_q == 3'h1)
        else $error("core step without a functional write");
    tag_pad_a: assert property (asb_rvalid_q && test_mode_q == 3'h2 |-> asb_rdata_q[5:0] == 6'h00)
        else $error("tag read low bits not zero");
    inputs_cause_a: assert property ($changed(core_input_vector_q) |-> $past(wr_take))
        else $error("core inputs changed without a write");
endmodule
bind bst_sequencer bst_sequencer_sva u_sva (.core_clk, .arst_n, .asb_sel, .asb_trans, .asb_write, .asb_addr,
    .asb_wdata, .asb_rdata_q, .asb_rvalid_q, .test_mode_q, .core_isolate_q, .core_step_q, .core_input_vector_q);

/* dv/bst_tester_model.sv */
// Tester model: bus master making single accesses to the sequencer
`timescale 1ns/1ps
module bst_tester_model
(
    input wire core_clk,           // Bus clock
    input wire [31:0] asb_rdata_q, // Read data
    input wire asb_rvalid_q,       // Read valid
    output reg asb_sel,            // Slave select
    output reg asb_trans,          // Transfer
    output reg asb_write,          // Direction
    output reg [11:0] asb_addr,    // Byte address
    output reg [31:0] asb_wdata    // Write data
);
    integer n_late = 0;
    initial
    begin
        asb_sel = 1'b0;
        asb_trans = 1'b0;
        asb_write = 1'b0;
        asb_addr = 12'h000;
        asb_wdata = 32'h0;
    end
    // Entered just after an edge; request held over the taking edge
    task access(input w, input [11:0] a, input [31:0] d, output [31:0] q);
        integer i;
        begin
            q = 32'h0;
            asb_sel = 1'b1;
            asb_trans = 1'b1;
            asb_write = w;
            asb_addr = a;
            asb_wdata = d;
            @(posedge core_clk);
            #1;
            asb_sel = 1'b0;
            asb_trans = 1'b0;
            // Released lines must not keep showing the last value
            asb_addr = ~a;
            asb_wdata = ~d;
            i = 0;
            while (!w && asb_rvalid_q !== 1'b1 && i < 4)
            begin
                @(posedge core_clk);
                #1;
                i = i + 1;
            end
            if (!w && asb_rvalid_q !== 1'b1)
                n_late = n_late + 1;
            q = asb_rdata_q;
            // One idle edge between requests keeps the core clock at most half the bus clock
            @(posedge core_clk);
            #1;
        end
    endtask
endmodule

/* dv/bst_sequencer_tb.sv */
// Self-checking testbench for the bus-slave test sequencer
`timescale 1ns/1ps
module bst_sequencer_tb;
    reg core_clk = 1'b0;
    reg arst_n = 1'b0;
    wire asb_sel, asb_trans, asb_write, asb_rvalid_q, core_isolate_q, core_step_q;
    wire [11:0] asb_addr;
    wire [31:0] asb_wdata, asb_rdata_q, vin_q, cpin_q, din_q;
    wire [2:0] test_mode_q;
    reg [31:0] wdo = 32'h1111_2222, cpo = 32'h3333_4444, cpi = 32'h5555_6666, adr_val = 32'h7777_8888;
    reg [31:0] st2 = 32'h9abc_def1;
    reg [21:0] st1 = 22'h2a_5a5a;
    reg [31:0] q;
    integer n_fail = 0, num_checks = 0, cyc = 0, n_step = 0;
    integer i, v, s;
    initial
        forever #2.5 core_clk = ~core_clk;
    // Core-side outputs are captured on the falling edge, away from the launching edge
    always @(negedge core_clk)
        if (core_step_q === 1'b1)
            n_step = n_step + 1;
    bst_tester_model tm (.core_clk(core_clk), .asb_rdata_q(asb_rdata_q), .asb_rvalid_q(asb_rvalid_q),
        .asb_sel(asb_sel), .asb_trans(asb_trans), .asb_write(asb_write), .asb_addr(asb_addr), .asb_wdata(asb_wdata));
    bst_sequencer dut (.core_clk(core_clk), .arst_n(arst_n), .asb_sel(asb_sel), .asb_trans(asb_trans),
        .asb_write(asb_write), .asb_addr(asb_addr), .asb_wdata(asb_wdata), .asb_rdata_q(asb_rdata_q),
        .asb_rvalid_q(asb_rvalid_q), .test_mode_q(test_mode_q), .core_isolate_q(core_isolate_q),
        .core_step_q(core_step_q), .core_input_vector_q(vin_q), .coproc_data_to_core_q(cpin_q),
        .core_read_data_in_q(din_q), .core_write_data_out(wdo), .coproc_data_out(cpo), .coproc_instr_out(cpi),
        .core_status_word_one(st1), .address_out(adr_val), .boundary_drive_enable(st2[31]),
        .debug_acknowledge(st2[30]), .ext_clock_echo(st2[29]), .instr_reg_echo(st2[28:25]),
        .range_out({st2[23], st2[24]}), .scan_chain_select_echo(st2[22:18]), .tap_state_echo(st2[17:14]),
        .tdo_out(st2[13]), .tdo_enable_n(st2[12]), .scan_clock_echo(st2[11:3]), .comms_receive_flag(st2[2]),
        .comms_transmit_flag(st2[1]), .internal_debug_request(st2[0]));
    task chk(input [31:0] g, input [31:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e)
            begin
                n_fail = n_fail + 1;
                $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
            end
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        tm.access(1'b1, a, d, q);
    endtask
    task rd(input [11:0] a);
        tm.access(1'b0, a, 32'h0, q);
    endtask
    task tick(input integer n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_func;
        reg [31:0] exp [0:5];
        begin
            wr(12'h000, 32'h1);
            tick(1);
            chk({29'h0, test_mode_q}, 32'h1);
            chk({31'h0, core_isolate_q}, 32'h1);
            // Read order: write data, coproc instruction, coproc data, status one, two, address
            exp[1] = cpi;
            exp[2] = cpo;
            // Clock echo bits of status two stay still here, so no mask is needed
            exp[3] = {10'h0, st1};
            exp[4] = st2;
            exp[5] = adr_val;
            // Two vectors show the walk wrapping back to the first write slot
            for (v = 0; v < 2; v = v + 1)
            begin
                // A fresh write-data value each vector keeps every read unmasked
                wdo = 32'h1111_2222 + v;
                exp[0] = wdo;
                wr(12'h7fc, v * 32'h0101_0101);
                wr(12'h7fc, 32'ha5a5_0000 + v);
                s = n_step;
                wr(12'h7fc, 32'h1234_5670 + v);
                tick(2);
                chk(n_step - s, 32'h1);
                chk(cpin_q, v * 32'h0101_0101);
                chk(vin_q, 32'ha5a5_0000 + v);
                chk(din_q, 32'h1234_5670 + v);
                for (i = 0; i < 6; i = i + 1)
                begin
                    rd(12'h7fc);
                    chk(q, exp[i]);
                end
                tick(1);
            end
            wr(12'h000, 32'h0);
            tick(1);
            chk({28'h0, test_mode_q, core_isolate_q}, 32'h0);
            $display("test functional done");
        end
    endtask
    task t_tag;
        begin
            wr(12'h000, 32'h2);
            tick(1);
            chk({29'h0, test_mode_q}, 32'h2);
            wr(12'h004, 32'h5);
            wr(12'h008, 32'h1);
            wr(12'h00c, 32'h0);
            for (i = 0; i < 4; i = i + 1)
                wr(12'h094, 32'h0);
            wr(12'h004, 32'h5);
            for (i = 0; i < 4; i = i + 1)
            begin
                rd(12'h098);
                chk(q, i * 32'h40);
            end
            wr(12'h004, 32'h3f);
            wr(12'h00c, 32'h1f7f_7f7f);
            wr(12'h010, 32'h0);
            wr(12'h010, 32'h0);
            wr(12'h004, 32'h3f);
            rd(12'h018);
            chk(q, 32'hffff_ffc0);
            rd(12'h018);
            chk(q, 32'h0);
            rd(12'h01c);
            chk(q, 32'h0);
            // Segment 5 shares its low bits with segment 1; its write must not land there
            wr(12'h008, 32'h5);
            wr(12'h004, 32'h5);
            wr(12'h00c, 32'h1f7f_7f7f);
            wr(12'h010, 32'h0);
            wr(12'h004, 32'h5);
            rd(12'h018);
            chk(q, 32'h0);
            wr(12'h008, 32'h1);
            wr(12'h004, 32'h5);
            rd(12'h018);
            chk(q, 32'h0);
            wr(12'h000, 32'h0);
            $display("test tag ram done");
        end
    endtask
    task end_of_test;
        begin
            n_fail = n_fail + tm.n_late;
            $display("checks %0d mismatches %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // Ceiling well above the roughly 120 cycles the tests need
    always @(posedge core_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    end
    initial
    begin
        tick(10);
        arst_n = 1'b1;
        chk({28'h0, test_mode_q, core_isolate_q}, 32'h0);
        t_func;
        t_tag;
        end_of_test;
    end
endmodule
